// ==== src/ctm_defines.svh ====
// register map, field positions and reset values of the cascaded timer
// assumes: included by bare name from the package and the design files
`ifndef CTM_DEFINES_SVH
`define CTM_DEFINES_SVH
// ==========================================================
// register byte offsets
`define CTM_OFF_LCTL 8'h00
`define CTM_OFF_UCTL 8'h04
`define CTM_OFF_PERL 8'h08
`define CTM_OFF_PERH 8'h0C
`define CTM_OFF_DUTL 8'h10
`define CTM_OFF_DUTH 8'h14
`define CTM_OFF_STS 8'h18
`define CTM_OFF_MASK 8'h1C
`define CTM_OFF_CNT 8'h20
// ==========================================================
// field positions
`define CTM_LO_BYTE 7:0
`define CTM_HI_BYTE 15:8
`define CTM_HALF 15:0
`define CTM_LCTL_SRC 2:0
`define CTM_UCTL_MODE 1:0
`define CTM_UCTL_RUN 3
`define CTM_UCTL_FFI 7
`define CTM_STS_MATCH 0
`define CTM_STS_DUTY 1
`define CTM_STS_BITS 1:0
// ==========================================================
// codes and reset values
`define CTM_SRC_EXT 3'h4
`define CTM_RST_SRC 3'h0
`define CTM_RST_BYTE 8'h00
`define CTM_RST_HALF 16'h0000
`define CTM_RST_WORD 32'h0000_0000
`define CTM_RST_STS 2'h0
`define CTM_BYTE_ONE 9'h001
`define CTM_BYTE_MAX 8'hFF
`define CTM_HALF_MAX 16'hFFFF
`endif

// ==== src/ctm_pkg.sv ====
// types shared by the cascaded timer modules
// assumes: ctm_defines.svh sits beside it
`include "ctm_defines.svh"
package ctm_pkg;
  // ==========================================================
  // counting modes, top code is illegal and stalls the counter
  typedef enum logic [1:0] {
    CTM_MODE_EVT = 2'h0,
    CTM_MODE_PWM = 2'h1,
    CTM_MODE_PPG = 2'h2
  } ctm_mode_t;
  // apb answer states, one-hot
  typedef enum logic [1:0] {
    CTM_AP_IDLE = 2'h1,
    CTM_AP_RESP = 2'h2
  } ctm_apb_t;
  // ==========================================================
  // whole state of the timer core
  typedef struct packed {
    ctm_apb_t apb;
    logic [31:0] rdata;
    logic slverr;
    logic [2:0] src;
    ctm_mode_t mode;
    logic run;
    logic ffi;
    logic [7:0] per_stage;
    logic [15:0] period;
    logic [7:0] duty_stage;
    logic [15:0] duty_buf;
    logic [15:0] duty_act;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic ev_d;
    logic tff;
    logic pwm_n;
    logic ppg_n;
    logic [1:0] sts;
    logic [1:0] mask;
    logic irq;
  } ctm_state_t;
  typedef struct packed {
    logic meta;
    logic q;
  } ctm_sync_state_t;
endpackage : ctm_pkg

// ==== src/ctm_sync.sv ====
// two-stage synchroniser for the event input pin
// assumes: input is asynchronous to pclk
`timescale 1ns/10ps
module ctm_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  ctm_pkg::ctm_sync_state_t s_ff;
  ctm_pkg::ctm_sync_state_t nxt_s;
  // ==========================================================
  // stage one feeds stage two only
  always_comb begin
    nxt_s.meta = async_in;
    nxt_s.q = s_ff.meta;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{meta: 1'h1, q: 1'h1};
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign sync_out = s_ff.q;
endmodule : ctm_sync

// ==== src/ctm_prescale.sv ====
// divider taps of pclk, one-cycle count strobe for the chosen tap
// assumes: source codes as in ctm_defines.svh; external code handled upstream
`timescale 1ns/10ps
`include "ctm_defines.svh"
module ctm_prescale #(
  parameter int DIV_W = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] src,
  output logic tick
);
  if (DIV_W < 11) begin : g_chk
    $error("ctm_prescale: DIV_W must be at least 11");
  end
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
  } ctm_pre_state_t;
  ctm_pre_state_t s_ff;
  ctm_pre_state_t nxt_s;
  // ==========================================================
  // tap k fires when the low k bits are all ones
  function automatic logic ctm_tap(input logic [DIV_W-1:0] d, input int k);
    logic [DIV_W-1:0] m;
    m = (DIV_W'(1) << k) - DIV_W'(1);
    return (d & m) == m;
  endfunction : ctm_tap
  always_comb begin
    nxt_s = s_ff;
    nxt_s.div = s_ff.div + DIV_W'(1);
    unique case (src)
      3'h0: nxt_s.tick = ctm_tap(s_ff.div, 11);
      3'h1: nxt_s.tick = ctm_tap(s_ff.div, 7);
      3'h2: nxt_s.tick = ctm_tap(s_ff.div, 5);
      3'h3: nxt_s.tick = ctm_tap(s_ff.div, 3);
      3'h5: nxt_s.tick = ctm_tap(s_ff.div, 1);
      3'h6: nxt_s.tick = 1'h1;
      default: nxt_s.tick = 1'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign tick = s_ff.tick;
endmodule : ctm_prescale

// ==== src/ctm_timer.sv ====
// cascaded 16-bit timer: event counter, pwm and ppg modes, apb slave
// assumes: apb master on pclk; event pin asynchronous and slow
//
// Summary of operation
// - event mode, running: each falling edge on the event pin adds one to the count
// - event mode, running: count equal to period clears it and raises interrupt
// - event mode period is unbuffered; software leaves it alone while running
// - pwm: duty match toggles; overflow toggles, clears and raises interrupt
// - pwm and ppg pins show the inverse of the toggle flip-flop
// - flip-flop loads from the initial bit and resets to zero
// - pwm duty goes to a buffer while running, moves over at interrupt
// - pwm duty read returns the active value until the next interrupt
// - stopping holds the pin; initial bit changed only by a later write
// - ppg: duty match toggles; period match toggles, clears and interrupts
// - ppg duty and period are unbuffered; software leaves them while running
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "ctm_defines.svh"
module ctm_timer #(
  parameter int DIV_W = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_input_pin,
  output logic pulse_width_out_n,
  output logic programmable_pulse_out_n,
  output logic match_interrupt
);
  ctm_pkg::ctm_state_t s_ff;
  ctm_pkg::ctm_state_t nxt_s;
  logic ev_sync;
  logic pre_tick;
  logic tick;
  logic ev_fall;
  logic access;
  logic wr;
  logic rd_sts;
  logic ctl_wr;
  logic duty_commit;
  logic [15:0] duty_new;
  logic [16:0] inc;
  logic hit_duty;
  logic hit_per;
  logic match;
  logic [32:0] rd;

  // ==========================================================
  // pin synchroniser and clock taps
  ctm_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(event_input_pin),
    .sync_out(ev_sync)
  );

  ctm_prescale #(
    .DIV_W(DIV_W)
  ) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .src(s_ff.src),
    .tick(pre_tick)
  );

  // ==========================================================
  // functions
  // cascade of two byte counters, result {overflow, high, low}
  function automatic logic [16:0] ctm_inc(input logic [7:0] hi, input logic [7:0] lo);
    logic [8:0] l;
    logic [8:0] h;
    l = {1'h0, lo} + `CTM_BYTE_ONE;
    h = {1'h0, hi} + {8'h00, l[8]};
    return {h, l[7:0]};
  endfunction : ctm_inc

  // read mux, result {unmapped, data}
  function automatic logic [32:0] ctm_rd(input logic [7:0] a, input ctm_pkg::ctm_state_t q);
    logic [31:0] d;
    logic miss;
    d = `CTM_RST_WORD;
    miss = 1'h0;
    unique case (a)
      `CTM_OFF_LCTL: d[`CTM_LCTL_SRC] = q.src;
      `CTM_OFF_UCTL: begin
        d[`CTM_UCTL_MODE] = q.mode;
        d[`CTM_UCTL_RUN] = q.run;
        d[`CTM_UCTL_FFI] = q.ffi;
      end
      `CTM_OFF_PERL: d[`CTM_LO_BYTE] = q.period[`CTM_LO_BYTE];
      `CTM_OFF_PERH: d[`CTM_LO_BYTE] = q.period[`CTM_HI_BYTE];
      `CTM_OFF_DUTL: d[`CTM_LO_BYTE] = q.duty_act[`CTM_LO_BYTE];
      `CTM_OFF_DUTH: d[`CTM_LO_BYTE] = q.duty_act[`CTM_HI_BYTE];
      `CTM_OFF_STS: d[`CTM_STS_BITS] = q.sts;
      `CTM_OFF_MASK: d[`CTM_STS_BITS] = q.mask;
      `CTM_OFF_CNT: d[`CTM_HALF] = {q.cnt_hi, q.cnt_lo};
      default: miss = 1'h1;
    endcase
    return {miss, d};
  endfunction : ctm_rd

  // ==========================================================
  // decode
  always_comb begin
    access = psel & penable & (s_ff.apb == ctm_pkg::CTM_AP_RESP);
    wr = access & pwrite;
    rd_sts = access & ~pwrite & (paddr == `CTM_OFF_STS);
    ctl_wr = wr & (paddr == `CTM_OFF_UCTL);
    duty_commit = wr & (paddr == `CTM_OFF_DUTH);
    duty_new = {pwdata[`CTM_LO_BYTE], s_ff.duty_stage};
    // event mode always counts pin edges; otherwise the chosen source
    ev_fall = s_ff.ev_d & ~ev_sync;
    if ((s_ff.mode == ctm_pkg::CTM_MODE_EVT) || (s_ff.src == `CTM_SRC_EXT)) begin
      tick = ev_fall;
    end else begin
      tick = pre_tick;
    end
    inc = ctm_inc(s_ff.cnt_hi, s_ff.cnt_lo);
    hit_duty = inc[`CTM_HALF] == s_ff.duty_act;
    hit_per = inc[`CTM_HALF] == s_ff.period;
    rd = ctm_rd(paddr, s_ff);
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    match = 1'h0;
    nxt_s.ev_d = ev_sync;

    // apb: answer one cycle into the access phase, registered data
    unique case (s_ff.apb)
      ctm_pkg::CTM_AP_IDLE: begin
        if (psel && penable) begin
          nxt_s.apb = ctm_pkg::CTM_AP_RESP;
          nxt_s.rdata = pwrite ? `CTM_RST_WORD : rd[31:0];
          nxt_s.slverr = rd[32];
        end
      end
      ctm_pkg::CTM_AP_RESP: begin
        nxt_s.apb = ctm_pkg::CTM_AP_IDLE;
        nxt_s.slverr = 1'h0;
      end
    endcase

    // counting, only while the run bit is set
    if (s_ff.run && tick) begin
      {nxt_s.cnt_hi, nxt_s.cnt_lo} = inc[`CTM_HALF];
      unique case (s_ff.mode)
        ctm_pkg::CTM_MODE_EVT: begin
          if (hit_per) begin
            {nxt_s.cnt_hi, nxt_s.cnt_lo} = `CTM_RST_HALF;
            match = 1'h1;
          end
        end
        ctm_pkg::CTM_MODE_PWM: begin
          if (hit_duty) begin
            nxt_s.tff = ~nxt_s.tff;
          end
          if (inc[16]) begin
            // overflow already wrapped the count to zero
            nxt_s.tff = ~nxt_s.tff;
            match = 1'h1;
            nxt_s.duty_act = s_ff.duty_buf;
          end
        end
        ctm_pkg::CTM_MODE_PPG: begin
          if (hit_duty) begin
            nxt_s.tff = ~nxt_s.tff;
          end
          if (hit_per) begin
            nxt_s.tff = ~nxt_s.tff;
            {nxt_s.cnt_hi, nxt_s.cnt_lo} = `CTM_RST_HALF;
            match = 1'h1;
          end
        end
        default: begin
          // illegal mode code freezes the count
          {nxt_s.cnt_hi, nxt_s.cnt_lo} = {s_ff.cnt_hi, s_ff.cnt_lo};
        end
      endcase
    end

    // register writes, taken at the completing edge
    if (wr) begin
      unique case (paddr)
        `CTM_OFF_LCTL: nxt_s.src = pwdata[`CTM_LCTL_SRC];
        `CTM_OFF_UCTL: begin
          nxt_s.mode = ctm_pkg::ctm_mode_t'(pwdata[`CTM_UCTL_MODE]);
          nxt_s.run = pwdata[`CTM_UCTL_RUN];
          nxt_s.ffi = pwdata[`CTM_UCTL_FFI];
          // the flip-flop is loaded only by a write that finds the counter
          // stopped, so the write that stops it keeps the pin level
          if (!s_ff.run) begin
            nxt_s.tff = pwdata[`CTM_UCTL_FFI];
            if (pwdata[`CTM_UCTL_RUN]) begin
              {nxt_s.cnt_hi, nxt_s.cnt_lo} = `CTM_RST_HALF;
            end
          end
        end
        // low byte waits in a stage; the high byte commits both
        `CTM_OFF_PERL: nxt_s.per_stage = pwdata[`CTM_LO_BYTE];
        `CTM_OFF_PERH: begin
          nxt_s.period = {pwdata[`CTM_LO_BYTE], s_ff.per_stage};
        end
        `CTM_OFF_DUTL: nxt_s.duty_stage = pwdata[`CTM_LO_BYTE];
        `CTM_OFF_DUTH: begin
          nxt_s.duty_buf = duty_new;
          // buffered only for a running pwm; a write landing on the
          // overflow tick wins, so the new duty is never half applied
          if (!(s_ff.run && (s_ff.mode == ctm_pkg::CTM_MODE_PWM)) || match) begin
            nxt_s.duty_act = duty_new;
          end
        end
        `CTM_OFF_MASK: nxt_s.mask = pwdata[`CTM_STS_BITS];
        default: ;
      endcase
    end

    // sticky status, cleared by reading it; a new event wins
    if (rd_sts) begin
      nxt_s.sts = s_ff.sts & ~s_ff.rdata[`CTM_STS_BITS];
    end
    nxt_s.sts[`CTM_STS_MATCH] = nxt_s.sts[`CTM_STS_MATCH] | match;
    nxt_s.sts[`CTM_STS_DUTY] = nxt_s.sts[`CTM_STS_DUTY] | (s_ff.run & tick & hit_duty);
    nxt_s.irq = |(nxt_s.sts & nxt_s.mask);

    // pins are registered straight from the next flip-flop value
    nxt_s.pwm_n = ~nxt_s.tff;
    nxt_s.ppg_n = ~nxt_s.tff;
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff.apb <= ctm_pkg::CTM_AP_IDLE;
      s_ff.rdata <= `CTM_RST_WORD;
      s_ff.slverr <= 1'h0;
      s_ff.src <= `CTM_RST_SRC;
      s_ff.mode <= ctm_pkg::CTM_MODE_EVT;
      s_ff.run <= 1'h0;
      s_ff.ffi <= 1'h0;
      s_ff.per_stage <= `CTM_RST_BYTE;
      s_ff.period <= `CTM_RST_HALF;
      s_ff.duty_stage <= `CTM_RST_BYTE;
      s_ff.duty_buf <= `CTM_RST_HALF;
      s_ff.duty_act <= `CTM_RST_HALF;
      s_ff.cnt_lo <= `CTM_RST_BYTE;
      s_ff.cnt_hi <= `CTM_RST_BYTE;
      s_ff.ev_d <= 1'h1;
      s_ff.tff <= 1'h0;
      s_ff.pwm_n <= 1'h1;
      s_ff.ppg_n <= 1'h1;
      s_ff.sts <= `CTM_RST_STS;
      s_ff.mask <= `CTM_RST_STS;
      s_ff.irq <= 1'h0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.rdata;
  assign pready = s_ff.apb[1];
  assign pslverr = s_ff.slverr;
  assign pulse_width_out_n = s_ff.pwm_n;
  assign programmable_pulse_out_n = s_ff.ppg_n;
  assign match_interrupt = s_ff.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [15:0] cnt;
  logic step_ok;
  assign cnt = {s_ff.cnt_hi, s_ff.cnt_lo};
  assign step_ok = s_ff.run & tick & ~ctl_wr;

  sequence s_apb_req;
    psel && penable && !pready;
  endsequence
  sequence s_apb_done;
    pready ##1 !pready;
  endsequence

  a_apb_answer: assert property (s_apb_req |=> s_apb_done)
    else $error("apb answer not one cycle after access");

  a_event_count: assert property (
    step_ok && (s_ff.mode == ctm_pkg::CTM_MODE_EVT) && !hit_per
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("event edge did not add one");

  a_event_wrap: assert property (
    step_ok && (s_ff.mode == ctm_pkg::CTM_MODE_EVT) && hit_per
    |=> (cnt == `CTM_RST_HALF) && s_ff.sts[`CTM_STS_MATCH])
    else $error("event period match not taken");

  a_pwm_overflow: assert property (
    step_ok && (s_ff.mode == ctm_pkg::CTM_MODE_PWM) && inc[16] && !hit_duty
    |=> (cnt == `CTM_RST_HALF) && (s_ff.tff != $past(s_ff.tff))
        && s_ff.sts[`CTM_STS_MATCH])
    else $error("pwm overflow did not toggle and clear");

  a_pins_inverse: assert property (
    (pulse_width_out_n == programmable_pulse_out_n)
    && (pulse_width_out_n != s_ff.tff))
    else $error("output pins not inverse of flip-flop");

  a_ffi_load: assert property (
    ctl_wr && !s_ff.run |=> s_ff.tff == $past(pwdata[`CTM_UCTL_FFI]))
    else $error("flip-flop not loaded from initial bit");

  a_duty_buffer: assert property (
    duty_commit && s_ff.run && (s_ff.mode == ctm_pkg::CTM_MODE_PWM) && !match
    |=> s_ff.duty_act == $past(s_ff.duty_act))
    else $error("running pwm duty changed before interrupt");

  a_stop_hold: assert property (
    (!s_ff.run && !ctl_wr) [*2] |=> $stable(pulse_width_out_n))
    else $error("stopped output pin changed");

  a_ppg_period: assert property (
    step_ok && (s_ff.mode == ctm_pkg::CTM_MODE_PPG) && hit_per && !hit_duty
    |=> (cnt == `CTM_RST_HALF) && (s_ff.tff != $past(s_ff.tff)))
    else $error("ppg period match not taken");

  a_cascade_carry: assert property (
    step_ok && (s_ff.mode == ctm_pkg::CTM_MODE_PWM) && (s_ff.cnt_lo == `CTM_BYTE_MAX)
    && (cnt != `CTM_HALF_MAX)
    |=> (s_ff.cnt_lo == `CTM_RST_BYTE) && (s_ff.cnt_hi == $past(s_ff.cnt_hi) + 8'h01))
    else $error("low byte did not carry into high byte");

  a_irq_level: assert property (
    (s_ff.sts & s_ff.mask) != `CTM_RST_STS && !access |=> match_interrupt)
    else $error("unmasked status without interrupt");

endmodule : ctm_timer

// ==== bench/ctm_pulse_src.sv ====
// ==========================================================
// pulse source model for the event input pin
// assumes: called from the bench just after a pclk edge; pin idles high
`timescale 1ns/10ps
module ctm_pulse_src (
  input wire logic pclk,
  output logic event_input_pin
);
  logic lvl_ff = 1'b1;
  assign event_input_pin = lvl_ff;
  // ==========================================================
  // n falling edges; a shorter hold is raised to two cycles, narrower pulses may be lost
  task automatic pulse(input int n, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    repeat (n) begin
      lvl_ff <= 1'b0;
      repeat (h) @(posedge pclk);
      lvl_ff <= 1'b1;
      repeat (h) @(posedge pclk);
    end
  endtask : pulse
endmodule : ctm_pulse_src

// ==== bench/ctm_tb.sv ====
// ==========================================================
// self-checking bench for the cascaded timer over apb
// assumes: design and pulse source model compiled before it
`timescale 1ns/10ps
`include "ctm_defines.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic event_input_pin;
  logic pulse_width_out_n;
  logic programmable_pulse_out_n;
  logic match_interrupt;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  always #12.5 pclk = ~pclk;
  ctm_timer #(.DIV_W(11)) dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .event_input_pin(event_input_pin),
    .pulse_width_out_n(pulse_width_out_n),
    .programmable_pulse_out_n(programmable_pulse_out_n),
    .match_interrupt(match_interrupt)
  );
  ctm_pulse_src src (
    .pclk(pclk),
    .event_input_pin(event_input_pin)
  );
  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one idle edge at the end so the next call never re-assigns psel in the same step
  // waits as long as the slave needs; only the watchdog ends a hung transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp & m, rd & m);
  endtask : rdchk
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, a, {24'h00_0000, v[7:0]});
    apb(1'b1, a + 8'h04, {24'h00_0000, v[15:8]});
  endtask : wr16
  task automatic wait_for(input bit irq, input logic lvl, input int lim, output int k);
    k = 0;
    while ((irq ? match_interrupt : pulse_width_out_n) !== lvl && k < lim) begin
      @(posedge pclk);
      k++;
    end
    if (k >= lim) begin
      chk("wait limit", 32'(lvl), 32'(irq ? match_interrupt : pulse_width_out_n));
    end
  endtask : wait_for
  // ==========================================================
  // scenarios
  task automatic t_reset();
    // pins are watched straight, as through a port latch held at one
    chk("pwm pin", 32'h1, 32'(pulse_width_out_n));
    chk("irq", 32'h0, 32'(match_interrupt));
    rdchk("count", `CTM_OFF_CNT, 32'h0000_FFFF, 32'h0);
    apb(1'b1, 8'h24, 32'h0000_00FF);
    rdchk("unmapped", 8'h24, 32'hFFFF_FFFF, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    $display("test reset done");
  endtask : t_reset
  task automatic t_event();
    apb(1'b1, `CTM_OFF_UCTL, 32'h0);
    apb(1'b1, `CTM_OFF_LCTL, {29'h0, `CTM_SRC_EXT});
    wr16(`CTM_OFF_PERL, 16'h0101);
    apb(1'b1, `CTM_OFF_MASK, 32'h1);
    apb(1'b1, `CTM_OFF_UCTL, 32'h0000_0008);
    src.pulse(256, 2);
    repeat (6) @(posedge pclk);
    rdchk("count carry", `CTM_OFF_CNT, 32'h0000_FFFF, 32'h0000_0100);
    chk("irq early", 32'h0, 32'(match_interrupt));
    src.pulse(1, 5);
    repeat (6) @(posedge pclk);
    chk("irq match", 32'h1, 32'(match_interrupt));
    rdchk("count cleared", `CTM_OFF_CNT, 32'h0000_FFFF, 32'h0);
    rdchk("status", `CTM_OFF_STS, 32'h1, 32'h1);
    chk("irq cleared", 32'h0, 32'(match_interrupt));
    src.pulse(1, 3);
    repeat (6) @(posedge pclk);
    rdchk("count again", `CTM_OFF_CNT, 32'h0000_FFFF, 32'h1);
    apb(1'b1, `CTM_OFF_UCTL, 32'h0);
    $display("test event done");
  endtask : t_event
  task automatic t_pwm();
    apb(1'b1, `CTM_OFF_LCTL, 32'h6);
    apb(1'b1, `CTM_OFF_UCTL, 32'h1);
    wr16(`CTM_OFF_DUTL, 16'h0010);
    rdchk("duty stopped", `CTM_OFF_DUTL, 32'hFF, 32'h10);
    apb(1'b1, `CTM_OFF_UCTL, 32'h9);
    wait_for(1'b0, 1'b0, 100, n);
    chk("pwm duty toggle", 32'h0, 32'(pulse_width_out_n));
    wr16(`CTM_OFF_DUTL, 16'h0020);
    rdchk("duty old", `CTM_OFF_DUTL, 32'hFF, 32'h10);
    wait_for(1'b1, 1'b1, 70000, n);
    chk("pwm wrap irq", 32'h1, 32'(match_interrupt));
    chk("pwm wrap pin", 32'h1, 32'(pulse_width_out_n));
    rdchk("pwm status", `CTM_OFF_STS, 32'h1, 32'h1);
    rdchk("duty new", `CTM_OFF_DUTL, 32'hFF, 32'h20);
    apb(1'b1, `CTM_OFF_UCTL, 32'h1);
    $display("test pwm done");
  endtask : t_pwm
  task automatic t_ppg();
    apb(1'b1, `CTM_OFF_MASK, 32'h0);
    apb(1'b1, `CTM_OFF_UCTL, 32'h2);
    wr16(`CTM_OFF_DUTL, 16'h0004);
    wr16(`CTM_OFF_PERL, 16'h000A);
    apb(1'b1, `CTM_OFF_UCTL, 32'h0000_000A);
    wait_for(1'b0, 1'b0, 100, n);
    wait_for(1'b0, 1'b1, 100, n);
    chk("ppg low span", 32'h6, 32'(n));
    chk("ppg pin pair", 32'(pulse_width_out_n), 32'(programmable_pulse_out_n));
    chk("masked irq", 32'h0, 32'(match_interrupt));
    rdchk("ppg status", `CTM_OFF_STS, 32'h1, 32'h1);
    apb(1'b1, `CTM_OFF_MASK, 32'h1);
    wait_for(1'b1, 1'b1, 20, n);
    chk("unmasked irq", 32'h1, 32'(match_interrupt));
    // catch the falling edge itself so the stop lands well inside the low span
    wait_for(1'b0, 1'b1, 100, n);
    wait_for(1'b0, 1'b0, 100, n);
    apb(1'b1, `CTM_OFF_UCTL, 32'h2);
    repeat (20) @(posedge pclk);
    chk("stop holds pin", 32'h0, 32'(programmable_pulse_out_n));
    apb(1'b1, `CTM_OFF_UCTL, 32'h2);
    chk("load ffi zero", 32'h1, 32'(programmable_pulse_out_n));
    apb(1'b1, `CTM_OFF_UCTL, 32'h0000_0082);
    chk("load ffi one", 32'h0, 32'(programmable_pulse_out_n));
    apb(1'b1, `CTM_OFF_UCTL, 32'h0000_000B);
    repeat (10) @(posedge pclk);
    rdchk("frozen count", `CTM_OFF_CNT, 32'h0000_FFFF, 32'h0);
    apb(1'b1, `CTM_OFF_UCTL, 32'h3);
    apb(1'b0, `CTM_OFF_STS, 32'h0);
    apb(1'b1, `CTM_OFF_MASK, 32'h0);
    $display("test ppg done");
  endtask : t_ppg
  // ==========================================================
  // verdict
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // the pwm wrap alone takes 65536 cycles, so the limit sits well above it
  initial begin
    repeat (95000) @(posedge pclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_event();
    t_pwm();
    t_ppg();
    summarize();
  end
endmodule : testbench
